/* common/chac_pkg.sv */
package chac_pkg;
    // ==========================================================
    // Card register byte addresses in attribute space.
    localparam logic [10:0] CHAC_OPTION_ADDR = 11'h200;
    localparam logic [10:0] CHAC_STATUS_ADDR = 11'h202;
    localparam logic [10:0] CHAC_PINREP_ADDR = 11'h204;
    localparam logic [10:0] CHAC_SOCKET_ADDR = 11'h206;
    // ==========================================================
    // Field positions.
    localparam int CHAC_OPT_SOFT_RESET_BIT = 7;
    localparam int CHAC_OPT_LEVEL_IRQ_BIT = 6;
    localparam int CHAC_STS_CHANGED_BIT = 7;
    localparam int CHAC_STS_PIN_ENABLE_BIT = 6;
    localparam int CHAC_STS_HOST_8BIT_BIT = 5;
    localparam int CHAC_STS_POWER_DOWN_BIT = 2;
    localparam int CHAC_STS_IRQ_PENDING_BIT = 1;
    localparam int CHAC_PIN_READY_CHANGE_BIT = 5;
    localparam int CHAC_PIN_READY_STATE_BIT = 1;
    localparam int CHAC_SOCK_COPY_NUMBER_BIT = 4;
    localparam logic [7:0] CHAC_REG_RESET = 8'h00;
    // ==========================================================
    // Configuration index values.
    localparam logic [5:0] CHAC_IDX_MEMORY = 6'h00;
    localparam logic [5:0] CHAC_IDX_CONTIG_IO = 6'h01;
    localparam logic [5:0] CHAC_IDX_PRIMARY_IO = 6'h02;
    localparam logic [5:0] CHAC_IDX_SECONDARY_IO = 6'h03;
    // ==========================================================
    // True IDE task file addresses.
    localparam logic [2:0] CHAC_IDE_DATA_ADDR = 3'h0;
    localparam logic [2:0] CHAC_IDE_ALT_STATUS_ADDR = 3'h6;
    // ==========================================================
    // Host command register map.
    localparam logic [3:0] CHAC_CMD_ADDR = 4'h0;
    localparam logic [3:0] CHAC_CMD_WDATA = 4'h1;
    localparam logic [3:0] CHAC_CMD_CTRL = 4'h2;
    localparam logic [3:0] CHAC_CMD_RDATA = 4'h3;
    localparam logic [3:0] CHAC_CMD_STATUS = 4'h4;
    // Access kinds held in the control register.
    typedef enum logic [2:0] {
        CHAC_KIND_ATTR,
        CHAC_KIND_IO,
        CHAC_KIND_MEM,
        CHAC_KIND_IDE_CMD,
        CHAC_KIND_IDE_CTL
    } chac_kind_t;
    // Lane forms.
    localparam logic [1:0] CHAC_FORM_BYTE = 2'h0;
    localparam logic [1:0] CHAC_FORM_WORD = 2'h1;
    localparam logic [1:0] CHAC_FORM_ODD = 2'h2;
    // ==========================================================
    // Timing in ns and cycles at 4 ns.
    localparam int CHAC_CLK_NS = 4;
    localparam int CHAC_SETUP_NS = 30;
    localparam int CHAC_STROBE_NS = 300;
    localparam int CHAC_HOLD_NS = 30;
    localparam int CHAC_SETUP_CYC = (CHAC_SETUP_NS + CHAC_CLK_NS - 1) / CHAC_CLK_NS;
    localparam int CHAC_STROBE_CYC = (CHAC_STROBE_NS + CHAC_CLK_NS - 1) / CHAC_CLK_NS;
    localparam int CHAC_HOLD_CYC = (CHAC_HOLD_NS + CHAC_CLK_NS - 1) / CHAC_CLK_NS;
endpackage : chac_pkg

/* hdl/chac_lanes.sv */
`timescale 1ns/1ps
module chac_lanes
(
    // Access shape
    input wire chac_pkg::chac_kind_t kind_i,
    input wire logic [1:0] form_i,
    input wire logic a0_i,
    input wire logic is_write_i,
    input wire logic [15:0] wdata_i,
    // Lane plan
    output logic [15:0] lanes_o,
    output logic [1:0] lane_oe_o,
    output logic ce1_n_o,
    output logic ce2_n_o
);
    import chac_pkg::*;
    always_comb
    begin
        lanes_o = 16'h0000;
        lane_oe_o = 2'b00;
        ce1_n_o = 1'b1;
        ce2_n_o = 1'b1;
        case (form_i)
            CHAC_FORM_WORD:
            begin
                ce1_n_o = 1'b0;
                ce2_n_o = 1'b0;
                lanes_o = wdata_i;
                lane_oe_o = (kind_i == CHAC_KIND_ATTR) ? 2'b01 : 2'b11;
            end
            CHAC_FORM_ODD:
            begin
                ce2_n_o = 1'b0;
                lanes_o = {wdata_i[7:0], 8'h00};
                lane_oe_o = (kind_i == CHAC_KIND_ATTR) ? 2'b00 : 2'b10;
            end
            default:
            begin
                ce1_n_o = 1'b0;
                lanes_o = {8'h00, wdata_i[7:0]};
                // An attribute byte at an odd address is ignored, so it is not driven.
                lane_oe_o = (kind_i == CHAC_KIND_ATTR && a0_i) ? 2'b00 : 2'b01;
            end
        endcase
        if (!is_write_i)
        begin
            lane_oe_o = 2'b00;
        end
    end
endmodule : chac_lanes

/* hdl/chac_host.sv */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Attribute cycles hold the register select low, byte/word/odd forms.
// - Memory task file cycles keep register select high, I/O strobes idle.
// - IDE straps hold the output enable grounded from the second clock after reset release.
// - Card hard reset follows command status bit 0; the host restarts no sequence after it.
// - Host never sets status bit 5 (low lanes only); I/O and memory word writes drive both lanes, IDE writes both only at the data register.
// - Copy number written to socket register before option register.
module chac_host
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Command port
    input wire logic [3:0] cmd_addr_i,
    input wire logic [31:0] cmd_wdata_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    output logic [31:0] cmd_rdata_o,
    // Card pins
    output logic [10:0] card_addr_o,
    output logic card_reg_n_o,
    output logic card_ce1_n_o,
    output logic card_ce2_n_o,
    output logic card_oe_n_o,
    output logic card_we_n_o,
    output logic card_iord_n_o,
    output logic card_iowr_n_o,
    output logic card_cs0_n_o,
    output logic card_cs1_n_o,
    output logic card_reset_o,
    input wire logic [15:0] card_data_i,
    output logic [15:0] card_data_o,
    output logic [1:0] card_data_oe_o,
    input wire logic card_ready_i,
    // Straps
    input wire logic ide_mode_i
);
    import chac_pkg::*;
    // ==========================================================
    // Command registers.
    typedef enum logic [1:0] {CHAC_IDLE, CHAC_SETUP, CHAC_STROBE, CHAC_HOLD} chac_state_t;
    chac_state_t state;
    logic [10:0] acc_addr;
    logic [15:0] acc_wdata;
    logic [15:0] acc_rdata;
    chac_kind_t acc_kind;
    logic [1:0] acc_form;
    logic acc_write;
    logic ide_latched;
    logic strap_taken;
    logic card_reset_req;
    logic [7:0] cnt;
    logic done_flag;
    logic [15:0] lanes;
    logic [1:0] lane_oe;
    logic ce1_n;
    logic ce2_n;
    logic start;
    logic active;
    assign start = cmd_wr_i && cmd_addr_i == CHAC_CMD_CTRL && state == CHAC_IDLE;
    assign active = state == CHAC_STROBE;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_addr <= 11'h000;
            acc_wdata <= 16'h0000;
            acc_kind <= CHAC_KIND_ATTR;
            acc_form <= CHAC_FORM_BYTE;
            acc_write <= 1'b0;
            card_reset_req <= 1'b0;
        end
        else if (cmd_wr_i)
        begin
            if (cmd_addr_i == CHAC_CMD_ADDR)
            begin
                acc_addr <= cmd_wdata_i[10:0];
            end
            if (cmd_addr_i == CHAC_CMD_WDATA)
            begin
                acc_wdata <= cmd_wdata_i[15:0];
            end
            if (start)
            begin
                acc_kind <= chac_kind_t'(cmd_wdata_i[2:0]);
                acc_form <= cmd_wdata_i[5:4];
                acc_write <= cmd_wdata_i[8];
            end
            if (cmd_addr_i == CHAC_CMD_STATUS)
            begin
                card_reset_req <= cmd_wdata_i[0];
            end
        end
    end
    // ==========================================================
    // Mode strap caught after reset release.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ide_latched <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            ide_latched <= ide_mode_i;
            strap_taken <= 1'b1;
        end
    end
    // ==========================================================
    // Access sequencer.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= CHAC_IDLE;
            cnt <= 8'h00;
        end
        else
        begin
            case (state)
                CHAC_IDLE:
                begin
                    if (start)
                    begin
                        state <= CHAC_SETUP;
                        cnt <= 8'(CHAC_SETUP_CYC);
                    end
                end
                CHAC_SETUP:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01)
                    begin
                        state <= CHAC_STROBE;
                        cnt <= 8'(CHAC_STROBE_CYC);
                    end
                end
                CHAC_STROBE:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01)
                    begin
                        state <= CHAC_HOLD;
                        cnt <= 8'(CHAC_HOLD_CYC);
                    end
                end
                CHAC_HOLD:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01)
                    begin
                        state <= CHAC_IDLE;
                    end
                end
                default:
                begin
                    state <= CHAC_IDLE;
                end
            endcase
        end
    end
    // Read data captured at the end of the strobe, lanes steered.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_rdata <= 16'h0000;
        end
        else if (active && cnt == 8'h01 && !acc_write)
        begin
            if (acc_kind == CHAC_KIND_ATTR)
            begin
                acc_rdata <= {8'h00, card_data_i[7:0]};
            end
            else if (acc_form == CHAC_FORM_ODD)
            begin
                acc_rdata <= {8'h00, card_data_i[15:8]};
            end
            else if (acc_form == CHAC_FORM_BYTE || acc_kind == CHAC_KIND_IDE_CTL)
            begin
                acc_rdata <= {8'h00, card_data_i[7:0]};
            end
            else
            begin
                acc_rdata <= card_data_i;
            end
        end
    end
    // Set wins over the clear from a new start.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            done_flag <= 1'b0;
        end
        else if (state == CHAC_HOLD && cnt == 8'h01)
        begin
            done_flag <= 1'b1;
        end
        else if (start)
        begin
            done_flag <= 1'b0;
        end
    end
    chac_lanes i_chac_lanes
    (
        .kind_i(acc_kind),
        .form_i(acc_form),
        .a0_i(acc_addr[0]),
        .is_write_i(acc_write),
        .wdata_i(acc_wdata),
        .lanes_o(lanes),
        .lane_oe_o(lane_oe),
        .ce1_n_o(ce1_n),
        .ce2_n_o(ce2_n)
    );
    // ==========================================================
    // Pin drive, registered.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            card_addr_o <= 11'h000;
            card_reg_n_o <= 1'b1;
            card_ce1_n_o <= 1'b1;
            card_ce2_n_o <= 1'b1;
            card_oe_n_o <= 1'b1;
            card_we_n_o <= 1'b1;
            card_iord_n_o <= 1'b1;
            card_iowr_n_o <= 1'b1;
            card_cs0_n_o <= 1'b1;
            card_cs1_n_o <= 1'b1;
            card_reset_o <= 1'b0;
            card_data_o <= 16'h0000;
            card_data_oe_o <= 2'b00;
        end
        else
        begin
            card_reset_o <= card_reset_req;
            card_oe_n_o <= 1'b1;
            card_we_n_o <= 1'b1;
            card_iord_n_o <= 1'b1;
            card_iowr_n_o <= 1'b1;
            if (ide_latched)
            begin
                card_oe_n_o <= 1'b0;
                card_reg_n_o <= 1'b1;
                card_ce1_n_o <= 1'b1;
                card_ce2_n_o <= 1'b1;
                card_addr_o <= {8'h00, acc_addr[2:0]};
                card_cs0_n_o <= !(state != CHAC_IDLE && acc_kind == CHAC_KIND_IDE_CMD);
                card_cs1_n_o <= !(state != CHAC_IDLE && acc_kind == CHAC_KIND_IDE_CTL);
                card_iord_n_o <= !(active && !acc_write);
                card_iowr_n_o <= !(active && acc_write);
                card_data_oe_o <= (state != CHAC_IDLE && acc_write)
                    ? ((acc_kind == CHAC_KIND_IDE_CMD && acc_addr[2:0] == CHAC_IDE_DATA_ADDR)
                       ? 2'b11 : 2'b01) : 2'b00;
                card_data_o <= acc_wdata;
            end
            else
            begin
                card_cs0_n_o <= 1'b1;
                card_cs1_n_o <= 1'b1;
                card_addr_o <= acc_addr;
                card_reg_n_o <= !(state != CHAC_IDLE && acc_kind != CHAC_KIND_MEM);
                card_ce1_n_o <= (state == CHAC_IDLE) ? 1'b1 : ce1_n;
                card_ce2_n_o <= (state == CHAC_IDLE) ? 1'b1 : ce2_n;
                if (acc_kind == CHAC_KIND_IO)
                begin
                    card_iord_n_o <= !(active && !acc_write);
                    card_iowr_n_o <= !(active && acc_write);
                end
                else
                begin
                    card_oe_n_o <= !(active && !acc_write);
                    card_we_n_o <= !(active && acc_write);
                end
                card_data_o <= lanes;
                card_data_oe_o <= (state == CHAC_IDLE) ? 2'b00 : lane_oe;
            end
        end
    end
    // ==========================================================
    // Command read port; card_ready_i is reported in bit 3, for the sequencing of option bit 7.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cmd_rdata_o <= 32'h00000000;
        end
        else if (cmd_rd_i)
        begin
            case (cmd_addr_i)
                CHAC_CMD_ADDR: cmd_rdata_o <= {21'h000000, acc_addr};
                CHAC_CMD_WDATA: cmd_rdata_o <= {16'h0000, acc_wdata};
                CHAC_CMD_RDATA: cmd_rdata_o <= {16'h0000, acc_rdata};
                CHAC_CMD_STATUS: cmd_rdata_o <= {27'h0000000, ide_latched, card_ready_i,
                    done_flag, state != CHAC_IDLE, card_reset_req};
                default: cmd_rdata_o <= 32'h00000000;
            endcase
        end
        else
        begin
            cmd_rdata_o <= 32'h00000000;
        end
    end
    // ==========================================================
    // Checks.
    strobe_len_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(card_we_n_o) |-> !card_we_n_o [*8])
        else $error("write strobe too short");
    ide_regsel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ide_latched |-> card_we_n_o && card_reg_n_o)
        else $error("ide cycle used attribute strobes");
    ide_cs_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(card_cs0_n_o == 1'b0 && card_cs1_n_o == 1'b0))
        else $error("both chip selects low");
    mem_regsel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !card_oe_n_o && !ide_latched && acc_kind == CHAC_KIND_MEM |-> card_reg_n_o
        && card_iord_n_o)
        else $error("memory cycle with register select low");
    attr_lane_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !card_we_n_o && !card_reg_n_o |-> !card_data_oe_o[1])
        else $error("attribute write drove upper lanes");
    io_regsel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !card_iowr_n_o && !ide_latched |-> !card_reg_n_o)
        else $error("io write with register select high");
    done_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state == CHAC_HOLD && cnt == 8'h01 |=> done_flag && state == CHAC_IDLE)
        else $error("done not raised");
    io_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !card_iord_n_o |-> card_data_oe_o == 2'b00)
        else $error("host drove lanes during read");
endmodule : chac_host

/* tb/chac_card_model.sv */
`timescale 1ns/1ps
module chac_card_model
#(
    parameter logic [7:0] ALT_STATUS = 8'h50
)
(
    // Clock and strap
    input wire logic clk_i,
    input wire logic ide_i,
    // Card pins
    input wire logic [10:0] addr_i,
    input wire logic reg_n_i,
    input wire logic ce1_n_i,
    input wire logic ce2_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic iord_n_i,
    input wire logic iowr_n_i,
    input wire logic cs0_n_i,
    input wire logic cs1_n_i,
    input wire logic reset_i,
    input wire logic [15:0] data_i,
    input wire logic [1:0] data_oe_i,
    output logic [15:0] data_o,
    output logic ready_o
);
    // ====
    // Storage and decode.
    logic [7:0] attr [4];
    logic [7:0] tf [16];
    logic [15:0] ide_word;
    logic [7:0] devctl;
    logic [7:0] junk = 8'hA5;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] wd;
    logic lo_en;
    logic hi_en;
    logic ide_acc;
    logic wide;
    logic oddf;
    logic attr_hit;
    logic [3:0] ev;
    logic rdy_q = 1'b1;
    logic [7:0] sts_view;
    logic [7:0] pin_view;
    initial attr = '{default: 8'h00};
    always @(posedge clk_i) junk <= junk + 8'h3B;
    assign ide_acc = ide_i && (cs0_n_i != cs1_n_i);
    assign wide = !ce1_n_i && !ce2_n_i;
    assign oddf = ce1_n_i && !ce2_n_i;
    assign ev = {addr_i[3:1], 1'b0};
    assign attr_hit = !ide_i && !reg_n_i && (addr_i[10:3] == 8'h40);
    assign ready_o = !(reset_i || attr[0][7]);
    assign wd = {data_oe_i[1] ? data_i[15:8] : junk, data_oe_i[0] ? data_i[7:0] : junk};
    assign data_o = {hi_en ? hi : ~junk, lo_en ? lo : junk};
    // The model raises no interrupt; bit 0 reads 0, and the pending bit 1 returns the written bit 2.
    assign sts_view = {attr[2][5], attr[1][6:5], 3'h0, attr[1][2], 1'b0};
    assign pin_view = {attr[2][7:2], ready_o, attr[2][0]};
    always @(posedge clk_i)
    begin
        rdy_q <= ready_o;
        if (rdy_q != ready_o)
            attr[2][5] <= 1'b1;
    end
    // ====
    // Read lanes; undriven lanes carry a changing pattern.
    always_comb
    begin
        lo = junk;
        hi = junk;
        lo_en = 1'b0;
        hi_en = 1'b0;
        if (ide_acc && !iord_n_i)
        begin
            lo_en = 1'b1;
            hi_en = !cs0_n_i && addr_i[2:0] == 3'h0;
            lo = !cs1_n_i ? ALT_STATUS : (hi_en ? ide_word[7:0] : tf[addr_i[3:0]]);
            hi = ide_word[15:8];
        end
        else if (!ide_i && (!ce1_n_i || !ce2_n_i))
        begin
            if (attr_hit && !oe_n_i)
            begin
                lo_en = !oddf;
                lo = (wide || !addr_i[0]) ? ((addr_i[2:1] == 2'h1) ? sts_view :
                    (addr_i[2:1] == 2'h2) ? pin_view : attr[addr_i[2:1]]) : junk;
            end
            else if ((!reg_n_i && !iord_n_i) || (reg_n_i && !oe_n_i))
            begin
                lo_en = !oddf;
                hi_en = wide || oddf;
                lo = (!wide && addr_i[0]) ? tf[ev + 4'h1] : tf[ev];
                hi = tf[ev + 4'h1];
            end
        end
    end
    // ====
    // Writes land on the trailing edge of the strobe.
    always @(posedge we_n_i or posedge iowr_n_i or posedge reset_i)
    begin
        if (reset_i)
            attr <= '{default: 8'h00};
        else if (ide_acc && !cs1_n_i)
            devctl <= wd[7:0];
        else if (ide_acc && addr_i[2:0] == 3'h0)
            ide_word <= wd;
        else if (ide_acc)
            tf[addr_i[3:0]] <= wd[7:0];
        else if (attr_hit && !ce1_n_i && !addr_i[0])
            attr[addr_i[2:1]] <= wd[7:0];
        else if (!ide_i && !attr_hit && (!ce1_n_i || !ce2_n_i))
        begin
            if (!oddf && (wide || !addr_i[0]))
                tf[ev] <= wd[7:0];
            if (!wide && !oddf && addr_i[0])
                tf[ev + 4'h1] <= wd[7:0];
            if (wide || oddf)
                tf[ev + 4'h1] <= wd[15:8];
        end
    end
endmodule : chac_card_model

/* tb/chac_host_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module chac_host_bench;
    import chac_pkg::*;
    logic clk_i;
    logic resetn_i = 1'b0;
    logic ide_mode_i = 1'b0;
    logic cmd_wr_i = 1'b0;
    logic cmd_rd_i = 1'b0;
    logic [3:0] cmd_addr_i = 4'h0;
    logic [31:0] cmd_wdata_i = 32'h0;
    logic [31:0] cmd_rdata_o;
    logic [10:0] addr;
    logic reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, cs0_n, cs1_n, card_reset_o, rdy;
    logic [15:0] to_card;
    logic [15:0] from_card;
    logic [1:0] data_oe;
    int fails = 0;
    int checked = 0;
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    chac_host i_chac_host (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i),
        .cmd_rdata_o(cmd_rdata_o), .card_addr_o(addr), .card_reg_n_o(reg_n),
        .card_ce1_n_o(ce1_n), .card_ce2_n_o(ce2_n), .card_oe_n_o(oe_n), .card_we_n_o(we_n),
        .card_iord_n_o(iord_n), .card_iowr_n_o(iowr_n), .card_cs0_n_o(cs0_n),
        .card_cs1_n_o(cs1_n), .card_reset_o(card_reset_o), .card_data_i(from_card),
        .card_data_o(to_card), .card_data_oe_o(data_oe), .card_ready_i(rdy),
        .ide_mode_i(ide_mode_i));
    chac_card_model i_chac_card_model (.clk_i(clk_i), .ide_i(ide_mode_i), .addr_i(addr),
        .reg_n_i(reg_n), .ce1_n_i(ce1_n), .ce2_n_i(ce2_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .iord_n_i(iord_n), .iowr_n_i(iowr_n), .cs0_n_i(cs0_n), .cs1_n_i(cs1_n),
        .reset_i(card_reset_o), .data_i(to_card), .data_oe_i(data_oe), .data_o(from_card),
        .ready_o(rdy));
    // ====
    // Command port cycles.
    task automatic cmd_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        cmd_wr_i <= 1'b1;
        @(posedge clk_i);
        cmd_wr_i <= 1'b0;
    endtask : cmd_wr
    task automatic cmd_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        cmd_addr_i <= a;
        cmd_rd_i <= 1'b1;
        @(posedge clk_i);
        cmd_rd_i <= 1'b0;
        #1 d = cmd_rdata_o;
    endtask : cmd_rd
    task automatic close_out();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic access(input chac_kind_t k, input logic [1:0] f, input logic w,
        input logic [10:0] a, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] s;
        int n;
        cmd_wr(CHAC_CMD_ADDR, {21'h0, a});
        cmd_wr(CHAC_CMD_WDATA, {16'h0, wd});
        cmd_wr(CHAC_CMD_CTRL, {23'h0, w, 2'h0, f, 1'b0, k});
        s = 32'h0;
        n = 0;
        while (!(s[2] === 1'b1 && s[1] === 1'b0) && n < 100)
        begin
            cmd_rd(CHAC_CMD_STATUS, s);
            n++;
        end
        if (n == 100)
        begin
            fails++;
            close_out();
        end
        cmd_rd(CHAC_CMD_RDATA, s);
        rd = s[15:0];
    endtask : access
    task automatic do_reset(input logic ide);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        ide_mode_i <= ide;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask : do_reset
    // ====
    // Scenarios.
    task automatic s_reset_state();
        logic [31:0] s;
        logic [15:0] r;
        cmd_rd(CHAC_CMD_STATUS, s);
        `CHK(s[1:0], 2'b00)
        `CHK({oe_n, we_n, iord_n, iowr_n, card_reset_o}, 5'b11110)
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_OPTION_ADDR, 16'h0, r);
        `CHK(r[7:0], CHAC_REG_RESET)
    endtask : s_reset_state
    task automatic s_attr();
        logic [15:0] r;
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b1, CHAC_SOCKET_ADDR, 16'h0010, r);
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b1, CHAC_OPTION_ADDR, 16'h0041, r);
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b1, 11'h201, 16'h0077, r);
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_SOCKET_ADDR, 16'h0, r);
        `CHK(r, 16'h0010)
        access(CHAC_KIND_ATTR, CHAC_FORM_WORD, 1'b0, CHAC_OPTION_ADDR, 16'h0, r);
        `CHK(r, 16'h0041)
        access(CHAC_KIND_ATTR, CHAC_FORM_WORD, 1'b1, CHAC_OPTION_ADDR, 16'hAB03, r);
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_OPTION_ADDR, 16'h0, r);
        `CHK(r, 16'h0003)
    endtask : s_attr
    task automatic s_soft();
        logic [31:0] s;
        logic [15:0] r;
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b1, CHAC_OPTION_ADDR, 16'h0080, r);
        cmd_rd(CHAC_CMD_STATUS, s);
        `CHK(s[3], 1'b0)
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b1, CHAC_OPTION_ADDR, 16'h0000, r);
        cmd_rd(CHAC_CMD_STATUS, s);
        `CHK(s[3], 1'b1)
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_STATUS_ADDR, 16'h0, r);
        `CHK(r[7:0], 8'h80)
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_PINREP_ADDR, 16'h0, r);
        `CHK(r[7:0], 8'h22)
    endtask : s_soft
    task automatic s_task(input chac_kind_t k);
        logic [15:0] r;
        access(k, CHAC_FORM_WORD, 1'b1, 11'h004, 16'hC3A5, r);
        access(k, CHAC_FORM_BYTE, 1'b1, 11'h005, 16'h005A, r);
        access(k, CHAC_FORM_WORD, 1'b0, 11'h004, 16'h0, r);
        `CHK(r, 16'h5AA5)
        access(k, CHAC_FORM_BYTE, 1'b0, 11'h005, 16'h0, r);
        `CHK(r[7:0], 8'h5A)
        access(k, CHAC_FORM_ODD, 1'b0, 11'h004, 16'h0, r);
        `CHK(r, 16'h005A)
    endtask : s_task
    task automatic s_creset();
        logic [15:0] r;
        cmd_wr(CHAC_CMD_STATUS, 32'h1);
        repeat (3) @(posedge clk_i);
        #1 `CHK(card_reset_o, 1'b1)
        cmd_wr(CHAC_CMD_STATUS, 32'h0);
        repeat (3) @(posedge clk_i);
        access(CHAC_KIND_ATTR, CHAC_FORM_BYTE, 1'b0, CHAC_SOCKET_ADDR, 16'h0, r);
        `CHK(r[7:0], CHAC_REG_RESET)
    endtask : s_creset
    task automatic s_ide();
        logic [31:0] s;
        logic [15:0] r;
        do_reset(1'b1);
        cmd_rd(CHAC_CMD_STATUS, s);
        `CHK(s[4], 1'b1)
        access(CHAC_KIND_IDE_CMD, CHAC_FORM_WORD, 1'b1, 11'h000, 16'h1234, r);
        access(CHAC_KIND_IDE_CMD, CHAC_FORM_BYTE, 1'b1, 11'h003, 16'h005C, r);
        access(CHAC_KIND_IDE_CMD, CHAC_FORM_WORD, 1'b0, 11'h000, 16'h0, r);
        `CHK(r, 16'h1234)
        access(CHAC_KIND_IDE_CMD, CHAC_FORM_BYTE, 1'b0, 11'h003, 16'h0, r);
        `CHK(r[7:0], 8'h5C)
        access(CHAC_KIND_IDE_CTL, CHAC_FORM_BYTE, 1'b1, 11'h006, 16'h0002, r);
        access(CHAC_KIND_IDE_CTL, CHAC_FORM_BYTE, 1'b0, 11'h006, 16'h0, r);
        `CHK(r[7:0], 8'h50)
        `CHK(i_chac_card_model.devctl, 8'h02)
    endtask : s_ide
    initial
    begin
        do_reset(1'b0);
        s_reset_state();
        s_attr();
        s_soft();
        s_task(CHAC_KIND_IO);
        s_task(CHAC_KIND_MEM);
        s_creset();
        s_ide();
        close_out();
    end
endmodule : chac_host_bench
